// file: core/rmof_pkg.sv
// Package of constants and types for the raw mosaic output formatter
package rmof_pkg;
  localparam int OUT_W = 16;
  localparam int ADDR_W = 4;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CAM_MODE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_RECONF = 4'hC;
  // Control and reconfiguration register field positions
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_MSB_ALIGN = 4;
  localparam int CTRL_PROGRESSIVE = 5;
  localparam int CTRL_PRE_XFORM = 6;
  localparam int CTRL_RECONF = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] CAM_MODE_RAW12 = 4'h1;
  localparam logic [3:0] CAM_MODE_RST = 4'h0;
  localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;
  typedef enum logic [1:0] {
    FMT_YUV = 2'h0,
    FMT_TM_RAW10 = 2'h1,
    FMT_TM_RAW12 = 2'h2
  } rmof_fmt_t;
  typedef enum logic [1:0] {
    MODE_OTHER = 2'h0,
    MODE_TM10 = 2'h1,
    MODE_TM12 = 2'h3,
    MODE_RAW12 = 2'h2
  } rmof_mode_t;
  localparam int WIDTH_RAW10 = 10;
  localparam int WIDTH_RAW12 = 12;
endpackage

// file: core/rmof_cfg_if.sv
// Interface carrying active configuration to the pixel datapath
`timescale 1ns/100ps
interface rmof_cfg_if;
  import rmof_pkg::*;
  rmof_mode_t mode;
  logic msb_align;
  modport src (output mode, output msb_align);
  modport dst (input mode, input msb_align);
endinterface

// file: core/rmof_datapath.sv
// Pixel datapath: packs samples onto the 16-bit output bus
`timescale 1ns/100ps
module rmof_datapath (
  input wire logic mclk,
  input wire logic rst,
  rmof_cfg_if.dst cfg,
  input wire logic in_fv,
  input wire logic in_lv,
  input wire logic in_emb,
  input wire logic [rmof_pkg::OUT_W-1:0] in_data,
  output logic out_fv,
  output logic out_lv,
  output logic [rmof_pkg::OUT_W-1:0] out_data
);
  import rmof_pkg::*;

  // ****************************************
  // Sample packing
  // ****************************************
  function automatic logic [OUT_W-1:0] pack(input logic [OUT_W-1:0] d, input int w,
                                            input logic msb);
    logic [OUT_W-1:0] m;
    m = (OUT_W'(1) << w) - OUT_W'(1);
    if (msb) begin
      pack = (d & m) << (OUT_W - w);
    end else begin
      pack = d & m;
    end
  endfunction

  logic raw_mode;
  logic pass;
  assign raw_mode = (cfg.mode != MODE_OTHER);
  assign pass = in_lv && (!in_emb || raw_mode);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_fv <= 1'b0;
      out_lv <= 1'b0;
    end else begin
      out_fv <= in_fv;
      out_lv <= pass;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_data <= '0;
    end else if (!pass) begin
      out_data <= '0;
    end else begin
      case (cfg.mode)
        MODE_TM10: out_data <= pack(in_data, WIDTH_RAW10, cfg.msb_align);
        MODE_TM12: out_data <= pack(in_data, WIDTH_RAW12, cfg.msb_align);
        MODE_RAW12: out_data <= pack(in_data, WIDTH_RAW12, cfg.msb_align);
        default: out_data <= in_data;
      endcase
    end
  end
endmodule

// file: core/rmof_top.sv
// Top level: Avalon-MM registers and configuration of the raw output formatter
`timescale 1ns/100ps
module rmof_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [rmof_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic in_fv,
  input wire logic in_lv,
  input wire logic in_emb,
  input wire logic [rmof_pkg::OUT_W-1:0] in_data,
  output logic out_fv,
  output logic out_lv,
  output logic [rmof_pkg::OUT_W-1:0] out_data
);
  import rmof_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [3:0] cam_mode_reg;
  logic ack_reg;
  logic reconf_req;
  logic wr_ok;
  logic rd_ok;
  rmof_mode_t mode_reg;
  rmof_mode_t mode_next;
  logic msb_reg;

  // Writes commit on the answer edge, where waitrequest stands low
  assign wr_ok = avs_write && ack_reg;
  assign rd_ok = avs_read && !ack_reg;
  assign reconf_req = wr_ok && avs_address == REG_RECONF && avs_byteenable[0]
                      && avs_writedata[CTRL_RECONF];

  // One wait cycle, answer on the second edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ok && avs_address == REG_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          ctrl_reg[i*8 +: 8] <= avs_writedata[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cam_mode_reg <= CAM_MODE_RST;
    end else if (wr_ok && avs_address == REG_CAM_MODE && avs_byteenable[0]) begin
      cam_mode_reg <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= BUS_UNMAPPED;
    end else if (rd_ok) begin
      case (avs_address)
        REG_CTRL: avs_readdata <= ctrl_reg;
        REG_CAM_MODE: avs_readdata <= {28'h0000000, cam_mode_reg};
        REG_STATUS: avs_readdata <= {29'h00000000, msb_reg, mode_reg};
        default: avs_readdata <= BUS_UNMAPPED;
      endcase
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  always_comb begin
    mode_next = mode_reg;
    if (!(ctrl_reg[CTRL_PROGRESSIVE] && ctrl_reg[CTRL_PRE_XFORM])) begin
      mode_next = MODE_OTHER;
    end else if (reconf_req && cam_mode_reg == CAM_MODE_RAW12) begin
      mode_next = MODE_RAW12;
    end else if (reconf_req || mode_reg != MODE_RAW12) begin
      case (ctrl_reg[CTRL_FMT_LSB +: 2])
        FMT_TM_RAW10: mode_next = MODE_TM10;
        FMT_TM_RAW12: mode_next = MODE_TM12;
        default: mode_next = MODE_OTHER;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_OTHER;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      msb_reg <= 1'b0;
    end else begin
      msb_reg <= ctrl_reg[CTRL_MSB_ALIGN];
    end
  end

  rmof_cfg_if cfg ();
  assign cfg.mode = mode_reg;
  assign cfg.msb_align = msb_reg;

  rmof_datapath u_dp (
    .mclk(mclk),
    .rst(rst),
    .cfg(cfg.dst),
    .in_fv(in_fv),
    .in_lv(in_lv),
    .in_emb(in_emb),
    .in_data(in_data),
    .out_fv(out_fv),
    .out_lv(out_lv),
    .out_data(out_data)
  );
endmodule

// file: verification/rmof_checker.sv
// Port checker of the raw output formatter
`timescale 1ns/100ps
module rmof_checker (
  input logic mclk,
  input logic rst,
  input logic [3:0] avs_address,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic avs_waitrequest,
  input logic in_emb,
  input logic [15:0] in_data,
  input logic out_lv,
  input logic [15:0] out_data
);
  logic [6:0] c;
  logic [3:0] k;
  logic [2:0] q;
  logic [15:0] d;
  logic r, e;
  wire g = c[5] && c[6];
  wire t = g && !r && c[1:0] == 2'h1;
  wire u = g && !r && c[1:0] == 2'h2;
  wire s = q == 3'h7 && out_lv;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk) {d, e} <= {in_data, in_emb};
  // Shadow of the settings, q counts quiet cycles since the last write
  always_ff @(posedge mclk or posedge rst)
    if (rst) {c, k, r, q} <= '0;
    else if (avs_write && !avs_waitrequest) begin
      q <= 3'h0;
      if (avs_address == 4'h0) begin
        c <= avs_writedata[6:0];
        if (!(avs_writedata[5] && avs_writedata[6])) r <= 1'b0;
      end
      if (avs_address == 4'h4) k <= avs_writedata[3:0];
      if (avs_address == 4'hC && avs_writedata[0]) r <= k == 4'h1;
    end else if (q != 3'h7) q <= q + 3'h1;
  tm10_pack_a: assert property (s && t && !c[4] |-> out_data == {6'h0, d[9:0]})
    else $error("tm10 pack");
  tm12_pack_a: assert property (s && u && !c[4] |-> out_data == {4'h0, d[11:0]})
    else $error("tm12 pack");
  raw_pack_a: assert property (s && g && r && !c[4] |-> out_data == {4'h0, d[11:0]})
    else $error("raw pack");
  msb12_a: assert property (s && (u || g && r) && c[4] |-> out_data == {d[11:0], 4'h0})
    else $error("msb12 pack");
  msb10_a: assert property (s && t && c[4] |-> out_data == {d[9:0], 6'h0})
    else $error("msb10 pack");
  emb_block_a: assert property (q == 3'h7 && e && !t && !u && !(g && r) |-> !out_lv)
    else $error("embedded passed");
  pass_thru_a: assert property (s && !g && !e |-> out_data == d)
    else $error("raw without gate");
endmodule

// file: verification/rmof_rx_model.sv
// Downstream video receiver that counts delivered pixels
`timescale 1ns/100ps
module rmof_rx_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lv,
  output logic [15:0] cnt
);
  always_ff @(posedge mclk or posedge rst)
    if (rst) cnt <= 16'h0;
    else if (lv) cnt <= cnt + 16'h1;
endmodule

// file: verification/rmof_top_tb.sv
// Bench of the raw output formatter
`timescale 1ns/100ps
module rmof_top_tb;
  logic mclk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, lv = 1'b0, em = 1'b0, fo, lo, wt;
  logic fv = 1'b0;
  logic [3:0] a = 4'h0;
  logic [31:0] wd = 32'h0, rq, q;
  logic [15:0] di = 16'h0, od, rc;
  int seed = 84, miscompares = 0, total_checks = 0, np = 0;
  // Status code over control value for each test
  logic [10:0] tv[9] = '{11'h001, 11'h021, 11'h161, 11'h362, 11'h571, 11'h772, 11'h060,
    11'h260, 11'h670};
  rmof_top dut_u (.mclk(mclk), .rst(rst), .avs_address(a), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rq), .avs_waitrequest(wt),
    .in_fv(fv), .in_lv(lv), .in_emb(em), .in_data(di), .out_fv(fo), .out_lv(lo),
    .out_data(od));
  rmof_rx_model rx_u (.mclk(mclk), .rst(rst), .lv(lo), .cnt(rc));
  function automatic logic [16:0] ex(logic [15:0] v, logic e, logic [2:0] m);
    if (m[1:0] == 2'h0) return e ? 17'h0 : {1'b1, v};
    if (m[1:0] == 2'h1) return {1'b1, m[2] ? {v[9:0], 6'h0} : {6'h0, v[9:0]}};
    return {1'b1, m[2] ? {v[11:0], 4'h0} : {4'h0, v[11:0]}};
  endfunction
  task automatic chk(string n, logic [31:0] s, e);
    total_checks++;
    if (s !== e) miscompares++;
    if (s !== e) $display("CHECK FAILED %s exp %h got %h", n, e, s);
  endtask
  task automatic bus(logic w, logic [3:0] ad, logic [31:0] d);
    int n = 0;
    @(posedge mclk) {a, wd, wr, rd} <= {ad, d, w, !w};
    do @(posedge mclk); while (wt !== 1'b0 && ++n < 20);
    q = rq;
    {wr, rd} <= 2'h0;
    if (n == 20) miscompares++;
  endtask
  task automatic px(logic e, logic [2:0] m);
    logic [15:0] v = 16'($random(seed));
    logic [16:0] x = ex(v, e, m);
    logic f = 1'($random(seed));
    @(posedge mclk) {fv, lv, em, di} <= {f, 1'b1, e, v};
    @(posedge mclk) lv <= 1'b0;
    @(negedge mclk) chk("pixel", 32'({fo, lo, od}), 32'({f, x}));
    np += x[16];
  endtask
  task automatic end_of_test(bit h);
    miscompares += h;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial forever #20 mclk = ~mclk;
  initial #40000 end_of_test(1'b1);
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b1, 4'h4, 32'h1);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 4'h0, 32'(tv[i][7:0]));
      if (i > 6) bus(1'b1, 4'hC, 32'h1);
      bus(1'b0, 4'h8, 32'h0);
      chk("status", q, 32'(tv[i][10:8]));
      for (int k = 0; k < 6; k++) px(k[0], tv[i][10:8]);
      $display("test %0d done", i);
    end
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("frame", 32'(fo), 32'(fv));
    chk("received", 32'(rc), 32'(np));
    end_of_test(1'b0);
  end
endmodule
bind rmof_top rmof_checker chk_u (.mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .in_emb(in_emb), .in_data(in_data), .out_lv(out_lv), .out_data(out_data));
